// ===== rcpp_defines.svh
// timing counts, defaults and field positions of the configuration port
`ifndef RCPP_DEFINES_SVH
`define RCPP_DEFINES_SVH
// ****************************************
// clock and basic clock cycle
// ****************************************
`define RCPP_CLK_NS 20
`define RCPP_BASIC_CYCLE_NS 2038
`define RCPP_BC_CLKS (`RCPP_BASIC_CYCLE_NS / `RCPP_CLK_NS)
// ****************************************
// pulse lengths in basic clock cycles
// ****************************************
`define RCPP_T1_MIN_BC 13'd16
`define RCPP_T1_SHORT_MAX_BC 13'd5632
`define RCPP_T1_LONG_BC 13'd7936
`define RCPP_T2_BC 13'd8
`define RCPP_T3_BC 13'd8
`define RCPP_T4_BC 13'd8
`define RCPP_T5_BC 13'd32
`define RCPP_T6_BC 13'd64
`define RCPP_T7_BC 13'd8
`define RCPP_T8_BC 13'd8
`define RCPP_T9_BC 13'd32
`define RCPP_RST_BC 13'd256
`define RCPP_RM_HALF_BC 13'd2048
// ****************************************
// configuration word
// ****************************************
`define RCPP_POLL_DEF 15'h0000
`define RCPP_LIMIT_DEF 15'h0a55
`define RCPP_OFF_BIT 14
`define RCPP_ADDR_BIT 13
`define RCPP_LAST_BIT 4'he
`endif

// ===== rcpp_pkg.sv
// types of the configuration port
package rcpp_pkg;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_DELAY = 4'h2,
      ST_BIT   = 4'h4,
      ST_EQUIV = 4'h8
   } rcpp_state_e;
endpackage : rcpp_pkg

// ===== rcpp_port.sv
// power-on reset, reset marker and serial configuration sequencer
`timescale 1ns/10ps
`include "rcpp_defines.svh"

// What this block does
// - supply below threshold raises power-on reset and loads default configuration.
// - power-on reset held a minimum period after supply recovers, then released.
// - power-on reset is also raised at first switch-on.
// - after reset, drive slow 50% square-wave reset marker on the data line.
// - host start pulse clears the marker when it qualifies.
// - after release the device becomes timing master of the line.
// - after programming delay, emit 15 sync low pulses of fixed length.
// - after each sync pulse, wait window delay, then open bit window.
// - host low pulse in window stores 0, otherwise 1.
// - each bit takes one fixed frame; 15 frames run back to back.
// - after last bit, acknowledge low pulse only if word equals addressed register.
// - transfers accepted in sleep and in active receive alike.
// - receive chain enables are low while a transfer runs.
// - bit 14 set makes the transfer an off command back to self-polling.
// - outside reset, start pulse between minimum and 5632 cycles launches transfer.
// - in reset state short start pulses are ignored and marker remains.
// - start pulse above 7936 cycles launches transfer from idle, in reset state or not, but not during power-on reset.
// - long start pulse reloads polling and limit defaults, clears marker.
module rcpp_port (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // supply comparator and open-drain data pin
   input wire logic supply_ok_in,
   input wire logic data_in,
   output logic data_out,
   output logic data_oe_out,
   // configuration and status
   output logic [14:0] poll_cfg_out,
   output logic [14:0] limit_cfg_out,
   output logic [4:0] rx_chain_en_out,
   output logic self_poll_out,
   output logic por_out,
   output logic marker_out
);
   // ****************************************
   // synchronisers and basic clock tick
   // ****************************************
   logic d_meta_ff, d_sync_ff, d_prev_ff, s_meta_ff, s_sync_ff, tick_ff, nxt_tick;
   logic [7:0] div_ff, nxt_div;

   always_comb begin
      nxt_div = div_ff + 8'h01;
      nxt_tick = 1'b0;
      if (div_ff == 8'(`RCPP_BC_CLKS - 1)) begin
         nxt_div = 8'h00;
         nxt_tick = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         d_meta_ff <= 1'b1;
         d_sync_ff <= 1'b1;
         d_prev_ff <= 1'b1;
         s_meta_ff <= 1'b0;
         s_sync_ff <= 1'b0;
         div_ff <= 8'h00;
         tick_ff <= 1'b0;
      end else begin
         d_meta_ff <= data_in;
         d_sync_ff <= d_meta_ff;
         d_prev_ff <= d_sync_ff;
         s_meta_ff <= supply_ok_in;
         s_sync_ff <= s_meta_ff;
         div_ff <= nxt_div;
         tick_ff <= nxt_tick;
      end
   end

   // ****************************************
   // power-on reset and reset marker
   // ****************************************
   logic por_ff, marker_ff, rm_lvl_ff, nxt_por, nxt_marker, nxt_rm_lvl, clear_marker;
   logic [12:0] rst_cnt_ff, rm_cnt_ff, nxt_rst_cnt, nxt_rm_cnt;

   always_comb begin
      nxt_por = por_ff;
      nxt_rst_cnt = rst_cnt_ff;
      nxt_marker = marker_ff;
      nxt_rm_lvl = rm_lvl_ff;
      nxt_rm_cnt = rm_cnt_ff;
      if (!s_sync_ff) begin
         nxt_por = 1'b1;
         nxt_rst_cnt = 13'h0000;
         nxt_marker = 1'b1;
      end else if (por_ff && tick_ff) begin
         // release only after the full period with supply good
         if (rst_cnt_ff >= `RCPP_RST_BC - 13'd1) begin
            nxt_por = 1'b0;
         end else begin
            nxt_rst_cnt = rst_cnt_ff + 13'd1;
         end
      end
      if (clear_marker) begin
         nxt_marker = 1'b0;
      end
      if (tick_ff) begin
         if (rm_cnt_ff >= `RCPP_RM_HALF_BC - 13'd1) begin
            nxt_rm_cnt = 13'h0000;
            nxt_rm_lvl = ~rm_lvl_ff;
         end else begin
            nxt_rm_cnt = rm_cnt_ff + 13'd1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         por_ff <= 1'b1;
         rst_cnt_ff <= 13'h0000;
         marker_ff <= 1'b1;
         rm_lvl_ff <= 1'b0;
         rm_cnt_ff <= 13'h0000;
      end else begin
         por_ff <= nxt_por;
         rst_cnt_ff <= nxt_rst_cnt;
         marker_ff <= nxt_marker;
         rm_lvl_ff <= nxt_rm_lvl;
         rm_cnt_ff <= nxt_rm_cnt;
      end
   end

   // ****************************************
   // start pulse, sequencer and registers
   // ****************************************
   rcpp_pkg::rcpp_state_e st_ff, nxt_st;
   logic [12:0] low_cnt_ff, cnt_ff, zlow_ff, nxt_low_cnt, nxt_cnt, nxt_zlow;
   logic [3:0] idx_ff, nxt_idx;
   logic [14:0] word_ff, poll_ff, limit_ff, nxt_word, nxt_poll, nxt_limit, new_word;
   logic zero_ff, eq_ff, oe_ff, self_poll_ff, nxt_zero, nxt_eq, nxt_oe, nxt_self_poll;
   logic [4:0] rx_en_ff, nxt_rx_en;
   logic release_edge, go_long, go_short, in_window, frame_end;

   assign release_edge = !d_prev_ff && d_sync_ff;
   // own marker lows are shorter than the long threshold, so they never launch
   assign go_long = release_edge && low_cnt_ff > `RCPP_T1_LONG_BC;
   assign go_short = release_edge && !marker_ff && low_cnt_ff > `RCPP_T1_MIN_BC
      && low_cnt_ff < `RCPP_T1_SHORT_MAX_BC;
   // a brown-out in the same cycle keeps the marker set
   assign clear_marker = st_ff == rcpp_pkg::ST_IDLE && !por_ff && s_sync_ff && go_long;
   assign in_window = cnt_ff >= `RCPP_T3_BC + `RCPP_T4_BC
      && cnt_ff < `RCPP_T3_BC + `RCPP_T4_BC + `RCPP_T5_BC;
   assign frame_end = tick_ff && cnt_ff == `RCPP_T6_BC - 13'd1;
   assign new_word = {word_ff[13:0], ~zero_ff};

   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_idx = idx_ff;
      nxt_word = word_ff;
      nxt_zlow = zlow_ff;
      nxt_zero = zero_ff;
      nxt_eq = eq_ff;
      nxt_poll = poll_ff;
      nxt_limit = limit_ff;
      nxt_self_poll = self_poll_ff;
      nxt_oe = 1'b0;
      nxt_low_cnt = 13'h0000;
      if (!d_sync_ff) begin
         nxt_low_cnt = low_cnt_ff;
         if (tick_ff && low_cnt_ff != 13'h1fff) begin
            nxt_low_cnt = low_cnt_ff + 13'd1;
         end
      end
      if (tick_ff && st_ff != rcpp_pkg::ST_IDLE) begin
         nxt_cnt = cnt_ff + 13'd1;
      end
      case (st_ff)
         rcpp_pkg::ST_IDLE: begin
            nxt_oe = marker_ff && rm_lvl_ff && !por_ff;
            // launch regardless of sleep or active receive
            if (!por_ff && (go_long || go_short)) begin
               nxt_st = rcpp_pkg::ST_DELAY;
               nxt_cnt = 13'h0000;
               if (go_long) begin
                  nxt_poll = `RCPP_POLL_DEF;
                  nxt_limit = `RCPP_LIMIT_DEF;
               end
            end
         end
         rcpp_pkg::ST_DELAY: begin
            if (tick_ff && cnt_ff == `RCPP_T2_BC - 13'd1) begin
               nxt_st = rcpp_pkg::ST_BIT;
               nxt_cnt = 13'h0000;
               nxt_idx = 4'h0;
               nxt_zero = 1'b0;
               nxt_zlow = 13'h0000;
            end
         end
         rcpp_pkg::ST_BIT: begin
            nxt_oe = cnt_ff < `RCPP_T3_BC;
            if (tick_ff && in_window) begin
               nxt_zlow = d_sync_ff ? 13'h0000 : zlow_ff + 13'd1;
               if (!d_sync_ff && zlow_ff >= `RCPP_T7_BC - 13'd1) begin
                  nxt_zero = 1'b1;
               end
            end
            if (frame_end) begin
               nxt_word = new_word;
               nxt_cnt = 13'h0000;
               nxt_zero = 1'b0;
               nxt_zlow = 13'h0000;
               nxt_idx = idx_ff + 4'h1;
               if (idx_ff == `RCPP_LAST_BIT) begin
                  nxt_st = rcpp_pkg::ST_EQUIV;
                  nxt_eq = new_word == (new_word[`RCPP_ADDR_BIT] ? limit_ff : poll_ff);
               end
            end
         end
         rcpp_pkg::ST_EQUIV: begin
            nxt_oe = eq_ff && cnt_ff < `RCPP_T8_BC;
            if (tick_ff && cnt_ff == `RCPP_T9_BC - 13'd1) begin
               nxt_st = rcpp_pkg::ST_IDLE;
               if (word_ff[`RCPP_OFF_BIT]) begin
                  nxt_self_poll = 1'b1;
               end else begin
                  nxt_self_poll = 1'b0;
                  if (word_ff[`RCPP_ADDR_BIT]) begin
                     nxt_limit = word_ff;
                  end else begin
                     nxt_poll = word_ff;
                  end
               end
            end
         end
         default: begin
            nxt_st = rcpp_pkg::ST_IDLE;
         end
      endcase
      if (!s_sync_ff || por_ff) begin
         // brown-out aborts any transfer and restores defaults
         if (!s_sync_ff) begin
            nxt_poll = `RCPP_POLL_DEF;
            nxt_limit = `RCPP_LIMIT_DEF;
            nxt_self_poll = 1'b0;
         end
         nxt_st = rcpp_pkg::ST_IDLE;
         nxt_oe = 1'b0;
      end
      nxt_rx_en = (nxt_st == rcpp_pkg::ST_IDLE && !nxt_por) ? 5'h1f : 5'h00;
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         st_ff <= rcpp_pkg::ST_IDLE;
         low_cnt_ff <= 13'h0000;
         cnt_ff <= 13'h0000;
         zlow_ff <= 13'h0000;
         idx_ff <= 4'h0;
         word_ff <= 15'h0000;
         poll_ff <= `RCPP_POLL_DEF;
         limit_ff <= `RCPP_LIMIT_DEF;
         zero_ff <= 1'b0;
         eq_ff <= 1'b0;
         oe_ff <= 1'b0;
         self_poll_ff <= 1'b0;
         rx_en_ff <= 5'h00;
      end else begin
         st_ff <= nxt_st;
         low_cnt_ff <= nxt_low_cnt;
         cnt_ff <= nxt_cnt;
         zlow_ff <= nxt_zlow;
         idx_ff <= nxt_idx;
         word_ff <= nxt_word;
         poll_ff <= nxt_poll;
         limit_ff <= nxt_limit;
         zero_ff <= nxt_zero;
         eq_ff <= nxt_eq;
         oe_ff <= nxt_oe;
         self_poll_ff <= nxt_self_poll;
         rx_en_ff <= nxt_rx_en;
      end
   end

   assign data_out = 1'b0;
   assign data_oe_out = oe_ff;
   assign poll_cfg_out = poll_ff;
   assign limit_cfg_out = limit_ff;
   assign rx_chain_en_out = rx_en_ff;
   assign self_poll_out = self_poll_ff;
   assign por_out = por_ff;
   assign marker_out = marker_ff;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   por_on_brownout_a: assert property (
      !s_sync_ff |=> por_ff && poll_ff == `RCPP_POLL_DEF && limit_ff == `RCPP_LIMIT_DEF)
      else $error("brown-out did not restore defaults");
   por_min_hold_a: assert property (
      $fell(por_ff) |-> $past(rst_cnt_ff) == `RCPP_RST_BC - 13'd1 && $past(s_sync_ff))
      else $error("power-on reset released early");
   por_at_start_a: assert property ($rose(nrst_in) |-> por_ff && marker_ff)
      else $error("no power-on reset after switch-on");
   marker_wave_a: assert property (
      st_ff == rcpp_pkg::ST_IDLE && marker_ff && !por_ff && s_sync_ff
      |=> oe_ff == $past(rm_lvl_ff))
      else $error("reset marker not driven");
   short_ignored_a: assert property (
      st_ff == rcpp_pkg::ST_IDLE && marker_ff && release_edge
      && low_cnt_ff <= `RCPP_T1_LONG_BC |=> st_ff == rcpp_pkg::ST_IDLE && marker_ff)
      else $error("short pulse acted in reset state");
   long_launch_a: assert property (
      clear_marker && s_sync_ff |=> st_ff == rcpp_pkg::ST_DELAY && !marker_ff
      && poll_ff == `RCPP_POLL_DEF && limit_ff == `RCPP_LIMIT_DEF)
      else $error("long start pulse not honoured");
   sync_pulse_a: assert property (
      st_ff == rcpp_pkg::ST_BIT && cnt_ff < `RCPP_T3_BC && s_sync_ff && !por_ff |=> oe_ff)
      else $error("sync pulse missing");
   bit_capture_a: assert property (
      st_ff == rcpp_pkg::ST_BIT && frame_end && s_sync_ff && !por_ff
      |=> word_ff == {$past(word_ff[13:0]), ~$past(zero_ff)} && cnt_ff == 13'h0000)
      else $error("bit not captured at frame end");
   chain_off_a: assert property (por_ff |-> rx_en_ff == 5'h00)
      else $error("receive chain enabled during power-on reset");
   chain_gate_a: assert property (
      st_ff != rcpp_pkg::ST_IDLE && nxt_st != rcpp_pkg::ST_IDLE |=> rx_chain_en_out == 5'h00)
      else $error("receive chain enabled during transfer");
   ack_pulse_a: assert property (
      st_ff == rcpp_pkg::ST_EQUIV && cnt_ff < `RCPP_T8_BC && s_sync_ff && !por_ff
      |=> oe_ff == $past(eq_ff))
      else $error("acknowledge does not follow comparison");

   long_start_c: cover property (clear_marker);
   ack_seen_c: cover property (st_ff == rcpp_pkg::ST_EQUIV && eq_ff && oe_ff);
   off_cmd_c: cover property ($rose(self_poll_ff));
endmodule : rcpp_port

// ===== rcpp_host_model.sv
// host microcontroller model pulling the shared open-drain data line
`timescale 1ns/10ps
`include "rcpp_defines.svh"
module rcpp_host_model (
   // clock
   input wire logic clk_in,
   // command from the bench
   input wire logic start_in,
   input wire logic [12:0] low_bc_in,
   // open-drain pull and status
   output logic pull_low_out,
   output logic busy_out
);
   logic [19:0] cnt_ff;
   initial begin
      pull_low_out = 1'b0;
      busy_out = 1'b0;
      cnt_ff = 20'h0;
   end
   // lengths counted in whole basic cycles of the device
   always @(posedge clk_in) begin
      if (start_in && !busy_out) begin
         cnt_ff <= 20'(low_bc_in) * 20'(`RCPP_BC_CLKS);
         pull_low_out <= 1'b1;
         busy_out <= 1'b1;
      end else if (busy_out) begin
         if (cnt_ff == 20'h0) begin
            pull_low_out <= 1'b0;
            busy_out <= 1'b0;
         end else begin
            cnt_ff <= cnt_ff - 20'h1;
         end
      end
   end
endmodule : rcpp_host_model

// ===== rcpp_port_bench.sv
// self-checking bench for the configuration port
`timescale 1ns/10ps
`include "rcpp_defines.svh"
module rcpp_port_bench;
   logic clk_in, nrst_in, supply_ok_in, data_in;
   logic data_out, data_oe_out, self_poll_out, por_out, marker_out;
   logic [14:0] poll_cfg_out, limit_cfg_out;
   logic [4:0] rx_chain_en_out;
   logic host_start, host_low, host_busy;
   logic [12:0] host_len;
   int num_errors, checks_done, cycles, seed_val;
   // long start pulses cannot fit the cycle budget, so only short ones run
   localparam int CYCLE_LIMIT = 90000;

   rcpp_port i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .supply_ok_in(supply_ok_in),
      .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out),
      .poll_cfg_out(poll_cfg_out), .limit_cfg_out(limit_cfg_out),
      .rx_chain_en_out(rx_chain_en_out), .self_poll_out(self_poll_out),
      .por_out(por_out), .marker_out(marker_out));
   rcpp_host_model i_host (.clk_in(clk_in), .start_in(host_start), .low_bc_in(host_len),
      .pull_low_out(host_low), .busy_out(host_busy));

   // pull-up: the line is low while either party pulls it
   assign data_in = ~(data_oe_out | host_low);
   always #10 clk_in = ~clk_in;

   // ****************************************
   // checking helpers
   // ****************************************
   function automatic logic [14:0] exp_rx_en(input logic chain_on);
      return chain_on ? 15'h001f : 15'h0000;
   endfunction : exp_rx_en

   task automatic check(input string name, input logic [14:0] seen, input logic [14:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : wait_clk

   task automatic check_defaults(input logic chain_on);
      check("poll_cfg", poll_cfg_out, `RCPP_POLL_DEF);
      check("limit_cfg", limit_cfg_out, `RCPP_LIMIT_DEF);
      check("rx_chain_en", 15'(rx_chain_en_out), exp_rx_en(chain_on));
      check("data_out", 15'(data_out), 15'h0000);
   endtask : check_defaults

   task automatic close_out;
      $display("checks_done %0d num_errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   // host start pulse, waited on with a bound of its own length
   task automatic host_pulse(input logic [12:0] len);
      int i;
      @(posedge clk_in);
      host_start <= 1'b1;
      host_len <= len;
      @(posedge clk_in);
      host_start <= 1'b0;
      i = 0;
      // busy is only seen once the model's update of this edge has settled
      #1;
      check("host_busy", 15'(host_busy), 15'h0001);
      while (host_busy === 1'b1 && i < int'(len) * `RCPP_BC_CLKS + 10) begin
         @(posedge clk_in);
         #1;
         i++;
      end
      check("host_done", 15'(host_busy), 15'h0000);
   endtask : host_pulse

   always @(posedge clk_in) begin
      cycles++;
      if (cycles == CYCLE_LIMIT) begin
         num_errors++;
         close_out();
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic [12:0] len;
      clk_in = 1'b0;
      nrst_in = 1'b0;
      supply_ok_in = 1'b0;
      host_start = 1'b0;
      host_len = 13'h0;
      num_errors = 0;
      checks_done = 0;
      cycles = 0;
      seed_val = $urandom(25942);
      wait_clk(6);
      // power-on state held while the supply is still low
      check("por", 15'(por_out), 15'h0001);
      check("marker", 15'(marker_out), 15'h0001);
      check("self_poll", 15'(self_poll_out), 15'h0000);
      check("oe_in_reset", 15'(data_oe_out), 15'h0000);
      check_defaults(1'b0);
      @(posedge clk_in);
      nrst_in <= 1'b1;
      $display("test power_on done");

      // reset period counted from supply recovery
      @(posedge clk_in);
      supply_ok_in <= 1'b1;
      wait_clk(250 * `RCPP_BC_CLKS);
      check("por_held", 15'(por_out), 15'h0001);
      check_defaults(1'b0);
      wait_clk(12 * `RCPP_BC_CLKS);
      check("por_released", 15'(por_out), 15'h0000);
      check("marker_after_por", 15'(marker_out), 15'h0001);
      check("marker_low_half", 15'(data_oe_out), 15'h0000);
      check_defaults(1'b1);
      $display("test reset_period done");

      // short start pulses must not clear the marker nor start a transfer
      for (int k = 0; k < 3; k++) begin
         len = (k == 0) ? 13'd17 : 13'(17 + $urandom_range(0, 50));
         host_pulse(len);
         wait_clk(20 * `RCPP_BC_CLKS);
         check("marker_kept", 15'(marker_out), 15'h0001);
         check("poll_kept", poll_cfg_out, `RCPP_POLL_DEF);
         check("no_transfer", 15'(rx_chain_en_out), exp_rx_en(1'b1));
         check("self_poll_idle", 15'(self_poll_out), 15'h0000);
      end
      $display("test short_pulse_ignored done");

      // brown-out glitch of random length
      @(posedge clk_in);
      supply_ok_in <= 1'b0;
      wait_clk(3 + $urandom_range(0, 7));
      check("por_brownout", 15'(por_out), 15'h0001);
      check("marker_brownout", 15'(marker_out), 15'h0001);
      check_defaults(1'b0);
      @(posedge clk_in);
      supply_ok_in <= 1'b1;
      wait_clk(250 * `RCPP_BC_CLKS);
      check("por_held_again", 15'(por_out), 15'h0001);
      wait_clk(12 * `RCPP_BC_CLKS);
      check("por_released_again", 15'(por_out), 15'h0000);
      check("marker_again", 15'(marker_out), 15'h0001);
      $display("test brownout done");
      close_out();
   end
endmodule : rcpp_port_bench
